// [src/cond_eval.sv]
`timescale 1ns/1ns
// Resolves one command's condition code into a fire decision for this sample.
module cond_eval
  import tts_pkg::*;
(
  input wire logic [CODE_W-1:0] code,
  input wire logic match,
  input wire logic [COUNT_W-1:0] count,
  input wire logic [COUNT_W-1:0] delay,
  output logic hit
);

  // Codes above eight are unused and treated as never true, so stale software values stay harmless.
  always_comb begin
    case (code)
      COND_MATCH: hit = match;
      COND_ALWAYS: hit = 1'b1;
      COND_NEVER: hit = 1'b0;
      COND_GT: hit = match && (count > delay);
      COND_LT: hit = match && (count < delay);
      COND_EQ: hit = match && (count == delay);
      COND_GE: hit = match && (count >= delay);
      COND_LE: hit = match && (count <= delay);
      COND_NE: hit = match && (count != delay);
      default: hit = 1'b0;
    endcase
  end

endmodule

// [src/trace_trigger_sequencer.sv]
`timescale 1ns/1ns
module trace_trigger_sequencer
  import tts_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic sample_clk,
  input wire logic [DATA_W-1:0] sample_data,
  output logic trace_store,
  output logic [LEVEL_W-1:0] level,
  output logic armed,
  output logic stopped
);

  // The whole state of the block, registered as one word.
  typedef struct packed {
    logic [1:0] clk_sync; // Target clock synchroniser, bit 0 is the first stage.
    logic clk_prev; // Previous synchronised target clock for edge detection.
    logic [DATA_W-1:0] d_s1; // First stage of the data synchroniser.
    logic [DATA_W-1:0] d_s2; // Second stage, aligned with clk_sync[1].
    logic armed; // Sequencer is acquiring.
    logic stopped; // A stop command fired since the last arm.
    logic [LEVEL_W-1:0] level; // Active level.
    logic [LEVEL_W-1:0] sel; // Level that the configuration window shows.
    logic [LEVEL_W-1:0] end_level; // Last level that advance may reach.
    logic [COUNT_W-1:0] count; // Sample counter of the active level.
    logic store; // One-cycle trace store pulse.
    logic [NUM_LEVELS-1:0][NUM_CMDS-1:0][DATA_W-1:0] pat; // Patterns per level and command.
    logic [NUM_LEVELS-1:0][NUM_CMDS-1:0][CODE_W-1:0] code; // Condition codes per level and command.
    logic [NUM_LEVELS-1:0][COUNT_W-1:0] delay; // Delay value per level.
    logic [NUM_LEVELS-1:0] by_pattern; // Delay counts pattern occurrences when set.
    logic [NUM_LEVELS-1:0][LEVEL_W-1:0] target; // Jump target per level.
    logic aw_have; // Write address held.
    logic [7:0] aw_addr;
    logic w_have; // Write data held.
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } state_s;

  state_s r; // Current state.
  state_s next_r; // Next state.
  logic [NUM_CMDS-1:0] match; // Data equals each command's pattern on the evaluated level.
  logic [NUM_CMDS-1:0] hit; // Each command fires on this sample.
  logic arm; // Software arms in this cycle.
  logic [LEVEL_W-1:0] eval_level; // Level the sample is judged on.
  logic [COUNT_W-1:0] eval_count; // Count the sample is judged on.

  // Byte-lane merge for AXI write strobes.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return res;
  endfunction

  // An arm write restarts the sequence; a sample in the same cycle is judged from level zero, not lost.
  always_comb begin
    logic aw_in;
    logic w_in;
    aw_in = awvalid && r.awready;
    w_in = wvalid && r.wready;
    // The arm fires on whichever edge completes the write, so a split address and data still arm.
    arm = (r.aw_have || aw_in) && (r.w_have || w_in) && !r.bvalid;
    arm = arm && ((aw_in ? awaddr : r.aw_addr) == REG_CTRL);
    arm = arm && (w_in ? (wstrb[0] && wdata[CTRL_ARM_BIT]) : (r.wstrb[0] && r.wdata[CTRL_ARM_BIT]));
    eval_level = arm ? '0 : r.level;
    eval_count = arm ? '0 : r.count;
    for (int i = 0; i < NUM_CMDS; i++) begin
      match[i] = (r.d_s2 == r.pat[eval_level][i]);
    end
  end

  // One evaluator per command slot; the four slots are alike.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CMDS; gi++) begin : g_cmd
      cond_eval u_cond (
        .code(r.code[eval_level][gi]),
        .match(match[gi]),
        .count(eval_count),
        .delay(r.delay[eval_level]),
        .hit(hit[gi])
      );
    end
  endgenerate

  // Next-state logic: bus slave first, then the sequencer on each rising target clock edge.
  always_comb begin
    logic strobe;
    logic [31:0] wv;
    logic [3:0] idx;
    strobe = 1'b0;
    wv = '0;
    idx = '0;
    next_r = r;
    // Pin synchronisers; only the second stage is read by logic.
    next_r.clk_sync = {r.clk_sync[0], sample_clk};
    next_r.clk_prev = r.clk_sync[1];
    next_r.d_s1 = sample_data;
    next_r.d_s2 = r.d_s1;
    strobe = r.clk_sync[1] && !r.clk_prev;
    next_r.store = 1'b0;

    // Write channel: address and data are taken in either order.
    if (awvalid && r.awready) begin
      next_r.aw_have = 1'b1;
      next_r.aw_addr = awaddr;
    end
    if (wvalid && r.wready) begin
      next_r.w_have = 1'b1;
      next_r.wdata = wdata;
      next_r.wstrb = wstrb;
    end
    if (r.bvalid && bready) begin
      next_r.bvalid = 1'b0;
    end
    if (next_r.aw_have && next_r.w_have && !r.bvalid) begin
      next_r.bvalid = 1'b1;
      next_r.bresp = RESP_OKAY;
      next_r.aw_have = 1'b0;
      next_r.w_have = 1'b0;
      case (next_r.aw_addr)
        REG_CTRL: begin
          // Arm is a self-clearing command bit; it is handled through the arm term.
        end
        REG_LEVEL_SEL: begin
          wv = merge({28'h0, r.sel}, next_r.wdata, next_r.wstrb);
          next_r.sel = wv[LEVEL_W-1:0];
        end
        REG_END_LEVEL: begin
          wv = merge({28'h0, r.end_level}, next_r.wdata, next_r.wstrb);
          next_r.end_level = wv[LEVEL_W-1:0];
        end
        8'h10, 8'h14, 8'h18, 8'h1c: begin
          idx = next_r.aw_addr[5:2] - REG_PAT_BASE[5:2];
          wv = merge({16'h0, r.pat[r.sel][idx[1:0]]}, next_r.wdata, next_r.wstrb);
          next_r.pat[r.sel][idx[1:0]] = wv[DATA_W-1:0];
        end
        REG_CODES: begin
          wv = merge({16'h0, r.code[r.sel]}, next_r.wdata, next_r.wstrb);
          next_r.code[r.sel] = wv[15:0];
        end
        REG_DELAY: begin
          wv = merge({15'h0, r.by_pattern[r.sel], r.delay[r.sel]}, next_r.wdata, next_r.wstrb);
          next_r.delay[r.sel] = wv[COUNT_W-1:0];
          next_r.by_pattern[r.sel] = wv[DELAY_MODE_BIT];
        end
        REG_JUMP: begin
          wv = merge({28'h0, r.target[r.sel]}, next_r.wdata, next_r.wstrb);
          next_r.target[r.sel] = wv[LEVEL_W-1:0];
        end
        REG_STATUS, REG_COUNT: begin
          // Read-only; the write is acknowledged and dropped.
        end
        default: begin
          next_r.bresp = RESP_SLVERR;
        end
      endcase
    end
    next_r.awready = !next_r.aw_have && !next_r.bvalid;
    next_r.wready = !next_r.w_have && !next_r.bvalid;

    // Read channel: one read at a time, answered the cycle after it is taken.
    if (r.rvalid && rready) begin
      next_r.rvalid = 1'b0;
    end
    if (arvalid && r.arready) begin
      next_r.rvalid = 1'b1;
      next_r.rresp = RESP_OKAY;
      next_r.rdata = '0;
      case (araddr)
        REG_CTRL: next_r.rdata = '0;
        REG_STATUS: next_r.rdata = {26'h0, r.stopped, r.armed, r.level};
        REG_LEVEL_SEL: next_r.rdata = {28'h0, r.sel};
        REG_END_LEVEL: next_r.rdata = {28'h0, r.end_level};
        8'h10, 8'h14, 8'h18, 8'h1c: begin
          idx = araddr[5:2] - REG_PAT_BASE[5:2];
          next_r.rdata = {16'h0, r.pat[r.sel][idx[1:0]]};
        end
        REG_CODES: next_r.rdata = {16'h0, r.code[r.sel]};
        REG_DELAY: next_r.rdata = {15'h0, r.by_pattern[r.sel], r.delay[r.sel]};
        REG_JUMP: next_r.rdata = {28'h0, r.target[r.sel]};
        REG_COUNT: next_r.rdata = {16'h0, r.count};
        default: next_r.rresp = RESP_SLVERR;
      endcase
    end
    next_r.arready = !next_r.rvalid;

    // Arming restarts at level zero with a clear count and drops any earlier stop.
    if (arm) begin
      next_r.armed = 1'b1;
      next_r.stopped = 1'b0;
      next_r.level = '0;
      next_r.count = '0;
    end

    // Sequencer step; a stopped sequencer stays frozen until the next arm.
    if (strobe && (arm || (r.armed && !r.stopped))) begin
      next_r.store = hit[CMD_TRACE];
      if (hit[CMD_STOP]) begin
        next_r.stopped = 1'b1;
        next_r.armed = 1'b0;
      end else if (hit[CMD_JUMP]) begin
        next_r.level = r.target[eval_level];
        next_r.count = '0;
      end else if (hit[CMD_ADV] && eval_level != r.end_level) begin
        next_r.level = eval_level + 4'h1;
        next_r.count = '0;
      end else if (eval_count != COUNT_MAX && (!r.by_pattern[eval_level] || match[CMD_ADV])) begin
        // The counter saturates rather than wrapping, so a long wait never aliases to a short one.
        next_r.count = eval_count + 16'h0001;
      end
    end
  end

  // State register; reset acts regardless of the clock enable.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.code <= {(NUM_LEVELS*NUM_CMDS){RST_CODE}};
      r.delay <= {NUM_LEVELS{RST_DELAY}};
    end else if (ce) begin
      r <= next_r;
    end
  end

  // Every output comes straight from the state register.
  assign awready = r.awready;
  assign wready = r.wready;
  assign bvalid = r.bvalid;
  assign bresp = r.bresp;
  assign arready = r.arready;
  assign rvalid = r.rvalid;
  assign rresp = r.rresp;
  assign rdata = r.rdata;
  assign trace_store = r.store;
  assign level = r.level;
  assign armed = r.armed;
  assign stopped = r.stopped;

endmodule

// [src/tts_pkg.sv]
package tts_pkg;

  // Sampled data width and sequencer geometry.
  localparam int DATA_W = 16;
  localparam int LEVEL_W = 4;
  localparam int NUM_LEVELS = 16;
  localparam int NUM_CMDS = 4;
  localparam int CODE_W = 4;
  localparam int COUNT_W = 16;

  // Command slots inside one level.
  localparam int CMD_STOP = 0;
  localparam int CMD_JUMP = 1;
  localparam int CMD_ADV = 2;
  localparam int CMD_TRACE = 3;

  // Condition codes carried by each command.
  localparam logic [3:0] COND_MATCH = 4'h0;
  localparam logic [3:0] COND_ALWAYS = 4'h1;
  localparam logic [3:0] COND_NEVER = 4'h2;
  localparam logic [3:0] COND_GT = 4'h3;
  localparam logic [3:0] COND_LT = 4'h4;
  localparam logic [3:0] COND_EQ = 4'h5;
  localparam logic [3:0] COND_GE = 4'h6;
  localparam logic [3:0] COND_LE = 4'h7;
  localparam logic [3:0] COND_NE = 4'h8;

  // Register byte offsets on the AXI4-Lite port.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_LEVEL_SEL = 8'h08;
  localparam logic [7:0] REG_END_LEVEL = 8'h0c;
  localparam logic [7:0] REG_PAT_BASE = 8'h10;
  localparam logic [7:0] REG_CODES = 8'h20;
  localparam logic [7:0] REG_DELAY = 8'h24;
  localparam logic [7:0] REG_JUMP = 8'h28;
  localparam logic [7:0] REG_COUNT = 8'h2c;

  // Field positions.
  localparam int CTRL_ARM_BIT = 0;
  localparam int DELAY_MODE_BIT = 16;
  localparam int STAT_ARMED_BIT = 4;
  localparam int STAT_STOPPED_BIT = 5;

  // Bus answers.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Reset values and the counter ceiling.
  localparam logic [15:0] RST_DELAY = 16'h0000;
  localparam logic [3:0] RST_CODE = COND_NEVER;
  localparam logic [15:0] COUNT_MAX = 16'hffff;

endpackage

// [testbench/target_model.sv]
`timescale 1ns/1ns
// Stands in for the probed target: its sampling clock and sampled data.
module target_model
  import tts_pkg::*;
(
  input wire logic aclk,
  output logic sample_clk,
  output logic [DATA_W-1:0] sample_data
);
  // The clock stands still low between samples.
  initial begin
    sample_clk = 1'b0;
    sample_data = '0;
  end
  // One sample: data set up first, clock high three clocks, then low six.
  // The data is spoilt once the clock is low, so a stale value cannot pass for a match.
  // Spoiling well before the task ends keeps it clear of the next sample's own data.
  task automatic sample(input logic [DATA_W-1:0] d);
    sample_data <= d;
    repeat (2) @(posedge aclk);
    sample_clk <= 1'b1;
    repeat (3) @(posedge aclk);
    sample_clk <= 1'b0;
    repeat (3) @(posedge aclk);
    sample_data <= ~d;
    repeat (3) @(posedge aclk);
  endtask
endmodule

// [testbench/trace_trigger_sequencer_test.sv]
`timescale 1ns/1ns
// Self-checking bench: register tasks note expected answers, a monitor compares.
module trace_trigger_sequencer_test
  import tts_pkg::*;
;
  logic aclk, aresetn = 1'b0, ce = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic rready = 1'b0, awready, wready, bvalid, arready, rvalid, trace_store, armed, stopped, sample_clk;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hf, level;
  logic [1:0] bresp, rresp;
  logic [DATA_W-1:0] sample_data;
  logic [33:0] exp_q[$]; // Expected {rresp, rdata} in order of request.
  logic [1:0] exp_b[$]; // Expected bresp in order of request.
  int error_cnt = 0, cmp_count = 0, cycles = 0, tr_cnt = 0, exp_tr;
  trace_trigger_sequencer dut (.aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .sample_clk, .sample_data, .trace_store, .level, .armed, .stopped);
  target_model tgt (.aclk, .sample_clk, .sample_data);
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  task automatic final_report();
    $display("errors=%0d compares=%0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check_val(input logic [33:0] got, input logic [33:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Write answer against the noted code.
  task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
    check_val({32'h0, got}, {32'h0, exp});
  endtask
  // Trace pulse tally against the count that the rules predict.
  task automatic check_cnt(input logic [15:0] got, input logic [15:0] exp);
    check_val({18'h0, got}, {18'h0, exp});
  endtask
  // Sequencer outputs, packed as {stopped, armed, level}.
  task automatic check_state(input logic [5:0] got, input logic [5:0] exp);
    check_val({28'h0, got}, {28'h0, exp});
  endtask
  // Takes the oldest note on each read or write handshake and counts trace pulses.
  always @(posedge aclk) begin
    if (rvalid === 1'b1 && rready === 1'b1) check_val({rresp, rdata}, exp_q.pop_front());
    if (bvalid === 1'b1 && bready === 1'b1) check_resp(bresp, exp_b.pop_front());
    if (trace_store === 1'b1) tr_cnt++;
  end
  // Cuts a hang short; the tests need well under a tenth of this.
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 40000) begin
      error_cnt++;
      final_report();
    end
  end
  // Write: address and data offered together, each dropped when taken.
  // With late set, bready waits until bvalid is seen, so a pending answer must hold.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY, input bit late = 1'b0);
    exp_b.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= !late;
    forever begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1 && bready === 1'b1) break;
      if (bvalid === 1'b1) bready <= 1'b1;
    end
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  // Read: the expected answer is noted before the request goes out.
  task automatic rd(input logic [7:0] a, input logic [33:0] e, input bit late = 1'b0);
    exp_q.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= !late;
    forever begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1 && rready === 1'b1) break;
      if (rvalid === 1'b1) rready <= 1'b1;
    end
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  // Programs one level; command i gets pattern pat xor i, so all differ.
  task automatic cfg(input logic [3:0] lv, input logic [15:0] codes, pat, dly, input logic [3:0] target);
    wr(REG_LEVEL_SEL, {28'h0, lv});
    for (int i = 0; i < NUM_CMDS; i++) wr(REG_PAT_BASE + 8'(4 * i), {16'h0, pat ^ 16'(i)});
    wr(REG_CODES, {16'h0, codes});
    wr(REG_DELAY, {16'h0, dly});
    wr(REG_JUMP, {28'h0, target});
  endtask
  // Expected outcome of a condition code, worked out independently.
  function automatic logic hit(input int c, input logic m, input int n, input int d);
    case (c)
      0: return m;
      1: return 1'b1;
      3: return m && n > d;
      4: return m && n < d;
      5: return m && n == d;
      6: return m && n >= d;
      7: return m && n <= d;
      8: return m && n != d;
      default: return 1'b0;
    endcase
  endfunction
  initial begin
    logic [15:0] p;
    logic m;
    void'($urandom(32'hb72d));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Reset values, an unmapped place and a read-only place.
    rd(REG_CODES, {RESP_OKAY, 32'h2222});
    rd(8'h30, {RESP_SLVERR, 32'h0});
    wr(8'h30, 32'h5, RESP_SLVERR);
    wr(REG_STATUS, 32'h3f, RESP_OKAY, 1'b1);
    rd(REG_STATUS, {RESP_OKAY, 32'h0}, 1'b1);
    // Every condition code on the trace command, delay 2, five random samples.
    for (int c = 0; c < 9; c++) begin
      p = 16'($urandom);
      cfg(4'h0, {4'(c), 12'h222}, p ^ 16'h3, 16'h2, 4'h0);
      wr(REG_CTRL, 32'h1);
      exp_tr = tr_cnt;
      for (int n = 0; n < 5; n++) begin
        m = 1'($urandom);
        tgt.sample(m ? p : p ^ 16'h8000);
        exp_tr += int'(hit(c, m, n, 2));
      end
      check_cnt(16'(tr_cnt), 16'(exp_tr));
      rd(REG_COUNT, {RESP_OKAY, 32'h5});
    end
    // Advance on its own pattern, then held at the end level.
    wr(REG_END_LEVEL, 32'h1);
    cfg(4'h1, 16'h2122, 16'h0, 16'h0, 4'h0);
    cfg(4'h0, 16'h0002, 16'h0a50, 16'h0, 4'h5);
    wr(REG_CTRL, 32'h1);
    exp_tr = tr_cnt;
    tgt.sample(16'h0a52);
    rd(REG_STATUS, {RESP_OKAY, 32'h11});
    tgt.sample(16'h0a52);
    rd(REG_COUNT, {RESP_OKAY, 32'h1});
    rd(REG_STATUS, {RESP_OKAY, 32'h11});
    check_state({stopped, armed, level}, 6'h11);
    check_cnt(16'(tr_cnt), 16'(exp_tr));
    // Jump beats advance; then stop beats jump while trace still fires.
    cfg(4'h5, 16'h1111, 16'h0, 16'h0, 4'h3);
    cfg(4'h0, 16'h2112, 16'h0, 16'h0, 4'h5);
    wr(REG_CTRL, 32'h1);
    tgt.sample(16'h1234);
    rd(REG_STATUS, {RESP_OKAY, 32'h15});
    rd(REG_COUNT, {RESP_OKAY, 32'h0});
    exp_tr = tr_cnt;
    tgt.sample(16'h1234);
    tgt.sample(16'h1234);
    rd(REG_STATUS, {RESP_OKAY, 32'h25});
    check_cnt(16'(tr_cnt), 16'(exp_tr + 1));
    check_state({stopped, armed, level}, 6'h25);
    // Delay counts advance-pattern occurrences; a sample while the clock enable is low is swallowed.
    cfg(4'h0, 16'h2222, 16'h0c00, 16'h0, 4'h0);
    wr(REG_DELAY, 32'h0001_0000);
    wr(REG_CTRL, 32'h1);
    tgt.sample(16'h0c02);
    tgt.sample(16'h0c00);
    tgt.sample(16'h0c02);
    ce <= 1'b0;
    tgt.sample(16'h0c02);
    ce <= 1'b1;
    rd(REG_COUNT, {RESP_OKAY, 32'h2});
    check_state({stopped, armed, level}, 6'h10);
    final_report();
  end
endmodule

// [testbench/tts_chk.sv]
`timescale 1ns/1ns
// Watches the bus handshakes and the sequencer outputs of the top module.
module tts_chk
  import tts_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic trace_store,
  input wire logic [3:0] level,
  input wire logic armed,
  input wire logic stopped
);
  // One clock domain, so clocking and reset are given once.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // A pending answer must not move until the master takes it.
  chk_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer changed while pending");
  chk_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer changed while pending");
  // While a write answer stands, a second write is refused, and so is a read if a read answer stands too.
  chk_no_overlap: assert property (bvalid |-> !awready && !wready && (!rvalid || !arready))
    else $error("request accepted while answer pending");
  // Unmapped places answer with an error and zero data.
  chk_rd_unmapped: assert property (ce && arvalid && arready && araddr >= 8'h30 |=> rvalid && rresp == RESP_SLVERR && rdata == 32'h0)
    else $error("unmapped read not refused");
  chk_wr_unmapped: assert property (ce && awvalid && awready && wvalid && wready && awaddr >= 8'h30 |=> bvalid && bresp == RESP_SLVERR)
    else $error("unmapped write not refused");
  // Samples are several clocks apart, so a trace pulse lasts one cycle.
  chk_trace_pulse: assert property (trace_store && ce |=> !trace_store)
    else $error("trace pulse too long");
  chk_stop_disarm: assert property ($rose(stopped) |-> !armed)
    else $error("stop left sequencer armed");
  chk_stop_freeze: assert property (stopped && $past(stopped) && !$rose(bvalid) |-> $stable(level))
    else $error("level moved while stopped");
  chk_level_cause: assert property ($changed(level) |-> $past(armed) || bvalid || $past(bvalid))
    else $error("level moved while idle");
endmodule

bind trace_trigger_sequencer tts_chk chk (.aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wvalid, .wready,
  .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .trace_store, .level,
  .armed, .stopped);
